// [rtl/ppic_pkg.sv]
// constants and carrier types shared by the priority interrupt scheduler
// assumes a single 25 MHz system clock domain
package ppic_pkg;

   // ------------------------------------------------------------
   // source counts and widths
   // ------------------------------------------------------------
   localparam int NUM_SW = 8;
   localparam int NUM_PERIPH = 356;
   localparam int NUM_ACTIVE = 191;
   localparam int NUM_SRC = NUM_SW + NUM_PERIPH;
   localparam int PRIO_W = 4;
   localparam int NUM_LEVELS = 16;
   localparam int VEC_W = 9;
   localparam int STACK_DEPTH = 16;
   localparam int DEPTH_W = 5;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // request to processor lags a peripheral edge by this many clocks
   localparam int REQ_LATENCY_CLK = 3;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_CUR_PRIO = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_VEC_ACK = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_END_HNDL = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_SW_REQ = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 12'h400;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_HW_VEC_BIT = 0;
   localparam int SW_SET_LSB = 0;
   localparam int SW_CLR_LSB = 8;
   localparam int STAT_VEC_LSB = 0;
   localparam int STAT_IRQ_BIT = 16;
   localparam int STAT_DEPTH_LSB = 24;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic RST_HW_VEC = 1'b0;
   localparam logic [PRIO_W-1:0] RST_PRIO = 4'h0;
   localparam logic [PRIO_W-1:0] RST_CUR_PRIO = 4'h0;
   localparam logic [VEC_W-1:0] RST_VEC = 9'h000;
   localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

   // winning request carried from the arbiter
   typedef struct packed {
      logic valid;
      logic [PRIO_W-1:0] prio;
      logic [VEC_W-1:0] vector;
   } ppic_win_t;

endpackage

// [rtl/ppic_arbiter.sv]
// combinational selection of the highest-priority pending source
// assumes pending and priority inputs are registered by the caller
`timescale 1ns/1ps

module ppic_arbiter (
   input wire logic [ppic_pkg::NUM_SRC-1:0] i_pending,
   input wire logic [ppic_pkg::PRIO_W-1:0] i_prio [ppic_pkg::NUM_SRC],
   output ppic_pkg::ppic_win_t o_win
);

   // ------------------------------------------------------------
   // linear scan
   // ------------------------------------------------------------
   // strict compare keeps the lowest index on a tie; level 0 never wins,
   // so a source at priority 0 is effectively disabled
   always_comb begin
      o_win = '0;
      for (int i = 0; i < ppic_pkg::NUM_SRC; i++) begin
         if (i_pending[i] && (i_prio[i] > o_win.prio)) begin
            o_win.valid = 1'b1;
            o_win.prio = i_prio[i];
            o_win.vector = ppic_pkg::VEC_W'(i);
         end
      end
   end

endmodule

// [rtl/ppic_scheduler.sv]
// priority_interrupt_scheduler: preemptive priority controller with Avalon-MM slave
// assumes one clock, async active-high reset, processor acks and ends handlers
//
// What this block does
// - each source holds one of sixteen priorities
// - request only when pending priority beats current
// - distinct 9-bit vector per source
// - push preempted priority on accept unless full, pop at end unless an accept comes in the same cycle
// - software may overwrite the current priority
// - eight software-settable request sources
// - 191 active plus 165 reserved peripheral inputs
// - peripheral to processor request in three clocks
// - vector by hardware port or register read
// - non-maskable interrupt bypasses this block entirely
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps

module ppic_scheduler (
   input wire logic i_clock,
   input wire logic i_rst,
   // peripheral request levels, positions at and above 191 are reserved
   input wire logic [ppic_pkg::NUM_PERIPH-1:0] i_periph_req,
   // processor handshake
   input wire logic i_hw_ack,
   input wire logic i_end_hndl,
   output logic o_irq,
   output logic [ppic_pkg::VEC_W-1:0] o_vector,
   // Avalon-MM slave
   input wire logic [ppic_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [ppic_pkg::DATA_W-1:0] i_avs_writedata,
   output logic [ppic_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest
);

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // priority table slot for a byte address
   function automatic logic [ppic_pkg::ADDR_W-1:0] prio_index(
      input logic [ppic_pkg::ADDR_W-1:0] addr
   );
      logic [ppic_pkg::ADDR_W-1:0] diff;
      diff = addr - ppic_pkg::OFS_PRIO_BASE;
      prio_index = {2'b00, diff[ppic_pkg::ADDR_W-1:2]};
   endfunction

   // true when a source index is implemented and not a reserved slot
   function automatic logic src_active(input logic [ppic_pkg::ADDR_W-1:0] idx);
      src_active = (idx < ppic_pkg::ADDR_W'(ppic_pkg::NUM_SW + ppic_pkg::NUM_ACTIVE));
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {PPIC_BUS_IDLE, PPIC_BUS_DONE} ppic_bus_t;

   ppic_bus_t bus_st_r;
   ppic_bus_t bus_st_nxt;
   logic hw_vec_r;
   logic [ppic_pkg::PRIO_W-1:0] cur_prio_r;
   logic [ppic_pkg::PRIO_W-1:0] cur_prio_nxt;
   logic [ppic_pkg::PRIO_W-1:0] prio_r [ppic_pkg::NUM_SRC];
   logic [ppic_pkg::PRIO_W-1:0] stack_r [ppic_pkg::STACK_DEPTH];
   logic [ppic_pkg::DEPTH_W-1:0] depth_r;
   logic [ppic_pkg::NUM_SW-1:0] sw_req_r;
   logic [ppic_pkg::NUM_SW-1:0] sw_req_nxt;
   logic [ppic_pkg::NUM_PERIPH-1:0] periph_r;
   ppic_pkg::ppic_win_t win_r;
   ppic_pkg::ppic_win_t win_c;
   logic irq_r;
   logic irq_nxt;
   logic [ppic_pkg::VEC_W-1:0] vector_r;
   logic [ppic_pkg::PRIO_W-1:0] irq_prio_r;
   logic [ppic_pkg::DATA_W-1:0] rdata_r;
   logic [ppic_pkg::DATA_W-1:0] rdata_nxt;
   logic wait_r;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // one wait state: the access is taken once, on the first cycle it is seen
   wire bus_take = (i_avs_read || i_avs_write) && (bus_st_r == PPIC_BUS_IDLE);
   wire wr_take = bus_take && i_avs_write;
   wire rd_take = bus_take && i_avs_read;
   wire sel_ctrl = (i_avs_address == ppic_pkg::OFS_CTRL);
   wire sel_cur = (i_avs_address == ppic_pkg::OFS_CUR_PRIO);
   wire sel_ack = (i_avs_address == ppic_pkg::OFS_VEC_ACK);
   wire sel_end = (i_avs_address == ppic_pkg::OFS_END_HNDL);
   wire sel_sw = (i_avs_address == ppic_pkg::OFS_SW_REQ);
   wire sel_stat = (i_avs_address == ppic_pkg::OFS_STATUS);
   wire [ppic_pkg::ADDR_W-1:0] pidx = prio_index(i_avs_address);
   wire sel_prio = (i_avs_address >= ppic_pkg::OFS_PRIO_BASE)
                   && (i_avs_address[1:0] == 2'b00)
                   && (pidx < ppic_pkg::ADDR_W'(ppic_pkg::NUM_SRC));
   wire prio_wr = wr_take && sel_prio && src_active(pidx);

   // ------------------------------------------------------------
   // acknowledge and end of handler
   // ------------------------------------------------------------
   // the vector path is chosen by software; the unused path is ignored so
   // a stray strobe cannot double-push the stack
   wire ack_hw = i_hw_ack && hw_vec_r;
   wire ack_sw = rd_take && sel_ack && !hw_vec_r;
   wire ack_ev = (ack_hw || ack_sw) && irq_r;
   wire end_ev = i_end_hndl || (wr_take && sel_end);
   wire stack_full = (depth_r == ppic_pkg::DEPTH_W'(ppic_pkg::STACK_DEPTH));
   wire stack_empty = (depth_r == '0);
   wire do_push = ack_ev && !stack_full;
   wire do_pop = end_ev && !ack_ev && !stack_empty;
   wire cur_wr = wr_take && sel_cur;
   wire [ppic_pkg::DEPTH_W-1:0] top_idx = depth_r - 1'b1;

   always_comb begin
      cur_prio_nxt = cur_prio_r;
      if (do_push) begin
         cur_prio_nxt = irq_prio_r;
      end else if (do_pop) begin
         cur_prio_nxt = stack_r[top_idx[3:0]];
      end else if (cur_wr) begin
         cur_prio_nxt = i_avs_writedata[ppic_pkg::PRIO_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // software-settable sources
   // ------------------------------------------------------------
   // a set and a clear of the same bit in one write leave it set
   always_comb begin
      sw_req_nxt = sw_req_r;
      if (wr_take && sel_sw) begin
         sw_req_nxt = (sw_req_r & ~i_avs_writedata[ppic_pkg::SW_CLR_LSB +: ppic_pkg::NUM_SW])
                      | i_avs_writedata[ppic_pkg::SW_SET_LSB +: ppic_pkg::NUM_SW];
      end
   end

   // ------------------------------------------------------------
   // request pipeline: capture, select, compare
   // ------------------------------------------------------------
   // reserved peripheral positions never reach the arbiter
   wire [ppic_pkg::NUM_PERIPH-1:0] active_mask =
      {{(ppic_pkg::NUM_PERIPH - ppic_pkg::NUM_ACTIVE){1'b0}},
       {ppic_pkg::NUM_ACTIVE{1'b1}}};
   wire [ppic_pkg::NUM_SRC-1:0] pending = {periph_r & active_mask, sw_req_r};

   ppic_arbiter u_arb (
      .i_pending(pending),
      .i_prio(prio_r),
      .o_win(win_c)
   );

   // compare against the priority that will stand after this edge, so an
   // accepted request drops at once instead of lingering for a cycle
   assign irq_nxt = win_r.valid && (win_r.prio > cur_prio_nxt) && !ack_ev;

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      rdata_nxt = ppic_pkg::RST_RDATA;
      if (sel_ctrl) begin
         rdata_nxt[ppic_pkg::CTRL_HW_VEC_BIT] = hw_vec_r;
      end else if (sel_cur) begin
         rdata_nxt[ppic_pkg::PRIO_W-1:0] = cur_prio_r;
      end else if (sel_ack) begin
         rdata_nxt[ppic_pkg::VEC_W-1:0] = vector_r;
      end else if (sel_sw) begin
         rdata_nxt[ppic_pkg::NUM_SW-1:0] = sw_req_r;
      end else if (sel_stat) begin
         rdata_nxt[ppic_pkg::STAT_VEC_LSB +: ppic_pkg::VEC_W] = vector_r;
         rdata_nxt[ppic_pkg::STAT_IRQ_BIT] = irq_r;
         rdata_nxt[ppic_pkg::STAT_DEPTH_LSB +: ppic_pkg::DEPTH_W] = depth_r;
      end else if (sel_prio) begin
         rdata_nxt[ppic_pkg::PRIO_W-1:0] = prio_r[pidx[8:0]];
      end
   end

   always_comb begin
      case (bus_st_r)
         PPIC_BUS_IDLE: bus_st_nxt = bus_take ? PPIC_BUS_DONE : PPIC_BUS_IDLE;
         PPIC_BUS_DONE: bus_st_nxt = PPIC_BUS_IDLE;
         default: bus_st_nxt = PPIC_BUS_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // bus slave registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         bus_st_r <= PPIC_BUS_IDLE;
         wait_r <= 1'b1;
         rdata_r <= ppic_pkg::RST_RDATA;
      end else begin
         bus_st_r <= bus_st_nxt;
         wait_r <= !bus_take;
         if (rd_take) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         hw_vec_r <= ppic_pkg::RST_HW_VEC;
         cur_prio_r <= ppic_pkg::RST_CUR_PRIO;
         sw_req_r <= '0;
      end else begin
         if (wr_take && sel_ctrl) begin
            hw_vec_r <= i_avs_writedata[ppic_pkg::CTRL_HW_VEC_BIT];
         end
         cur_prio_r <= cur_prio_nxt;
         sw_req_r <= sw_req_nxt;
      end
   end

   // ------------------------------------------------------------
   // priority table
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < ppic_pkg::NUM_SRC; i++) begin
            prio_r[i] <= ppic_pkg::RST_PRIO;
         end
      end else if (prio_wr) begin
         prio_r[pidx[8:0]] <= i_avs_writedata[ppic_pkg::PRIO_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // preempted priority stack
   // ------------------------------------------------------------
   // depth 16 covers every strictly rising nesting of 16 levels; a push
   // when full is dropped and the handler then cannot return its priority
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         depth_r <= '0;
         for (int i = 0; i < ppic_pkg::STACK_DEPTH; i++) begin
            stack_r[i] <= ppic_pkg::RST_PRIO;
         end
      end else if (do_push) begin
         stack_r[depth_r[3:0]] <= cur_prio_r;
         depth_r <= depth_r + 1'b1;
      end else if (do_pop) begin
         depth_r <= top_idx;
      end
   end

   // ------------------------------------------------------------
   // three-stage request pipeline
   // ------------------------------------------------------------
   // stage 1 samples inputs, stage 2 holds the winner, stage 3 drives the
   // processor; the non-maskable pin is wired to the core elsewhere and has
   // no input here
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         periph_r <= '0;
         win_r <= '0;
         irq_r <= 1'b0;
         vector_r <= ppic_pkg::RST_VEC;
         irq_prio_r <= ppic_pkg::RST_PRIO;
      end else begin
         periph_r <= i_periph_req;
         win_r <= win_c;
         irq_r <= irq_nxt;
         if (irq_nxt) begin
            vector_r <= win_r.vector;
            irq_prio_r <= win_r.prio;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_irq = irq_r;
   assign o_vector = vector_r;
   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = wait_r;

endmodule

// [testbench/ppic_scheduler_asserts.sv]
// port-level checks of the interrupt scheduler
// assumes one clock domain and the one-cycle bus answer of the design
`timescale 1ns/1ps

module ppic_scheduler_asserts (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [ppic_pkg::NUM_PERIPH-1:0] i_periph_req,
   input wire logic i_hw_ack,
   input wire logic i_end_hndl,
   input wire logic o_irq,
   input wire logic [ppic_pkg::VEC_W-1:0] o_vector,
   input wire logic [ppic_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [ppic_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [ppic_pkg::DATA_W-1:0] o_avs_readdata,
   input wire logic o_avs_waitrequest
);
   logic [ppic_pkg::NUM_PERIPH-1:0] req_d1_r, req_d2_r, req_d3_r;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         req_d1_r <= '0;
         req_d2_r <= '0;
         req_d3_r <= '0;
      end else begin
         req_d1_r <= i_periph_req;
         req_d2_r <= req_d1_r;
         req_d3_r <= req_d2_r;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |-> ##[1:2] !o_avs_waitrequest) else $error("bus request not answered");
   idle_wait_a: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
      else $error("bus answer without request");
   rst_values_a: assert property ($fell(i_rst) |-> !o_irq && o_vector == ppic_pkg::RST_VEC
      && o_avs_waitrequest && o_avs_readdata == ppic_pkg::RST_RDATA)
      else $error("outputs not at reset values");
   vec_range_a: assert property (o_irq |-> o_vector < 9'(ppic_pkg::NUM_SW + ppic_pkg::NUM_ACTIVE))
      else $error("request from a reserved position");
   periph_lat_a: assert property ($rose(o_irq) && o_vector >= 9'h008
      |-> req_d3_r[o_vector - 9'h008]) else $error("peripheral request latency wrong");
   ack_drop_a: assert property (o_irq && i_hw_ack |=> !o_irq)
      else $error("request stays after acknowledge");
   vec_hold_a: assert property (!o_irq ##1 !o_irq |-> $stable(o_vector))
      else $error("vector moved while idle");
   rdata_hold_a: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
      else $error("read data changed without read");

   cover property ($rose(o_irq));
   cover property (o_irq && i_hw_ack);
   cover property (i_end_hndl);
endmodule

bind ppic_scheduler ppic_scheduler_asserts ppic_scheduler_asserts_i (.i_clock(i_clock),
   .i_rst(i_rst), .i_periph_req(i_periph_req), .i_hw_ack(i_hw_ack),
   .i_end_hndl(i_end_hndl), .o_irq(o_irq), .o_vector(o_vector),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest));

// [testbench/ppic_cpu_model.sv]
// processor core model: takes a presented vector, later ends its handler
// assumes the scheduler is in hardware vector mode while i_en is high
`timescale 1ns/1ps

module ppic_cpu_model (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_irq,
   input wire logic [ppic_pkg::VEC_W-1:0] i_vector,
   input wire logic i_en,
   input wire logic [7:0] i_dly,
   output logic o_hw_ack,
   output logic o_end_hndl,
   output logic [ppic_pkg::VEC_W-1:0] o_taken_vec
);
   logic busy_r;
   logic [7:0] cnt_r;

   // one handler at a time; i_dly stretches both the ack and the handler body
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_hw_ack <= 1'b0;
         o_end_hndl <= 1'b0;
         o_taken_vec <= 9'h000;
         busy_r <= 1'b0;
         cnt_r <= 8'h00;
      end else begin
         o_hw_ack <= 1'b0;
         o_end_hndl <= 1'b0;
         cnt_r <= cnt_r + 8'h01;
         if (!i_en || !(busy_r || i_irq) || o_hw_ack || o_end_hndl) begin
            cnt_r <= 8'h00;
         end else if (cnt_r == i_dly) begin
            cnt_r <= 8'h00;
            busy_r <= !busy_r;
            o_hw_ack <= !busy_r;
            o_end_hndl <= busy_r;
            o_taken_vec <= busy_r ? o_taken_vec : i_vector;
         end
      end
   end
endmodule

// [testbench/test_ppic_scheduler.sv]
// self-checking bench of the interrupt scheduler with a processor model
// assumes package, design, checker and processor model compiled first
`timescale 1ns/1ps

module test_ppic_scheduler;
   logic i_clock, i_rst, rd, wr, cpu_en, hw_ack, end_hndl, irq, waitreq;
   logic [ppic_pkg::NUM_PERIPH-1:0] preq;
   logic [ppic_pkg::ADDR_W-1:0] addr;
   logic [ppic_pkg::DATA_W-1:0] wdata, rdata, q;
   logic [ppic_pkg::VEC_W-1:0] vec, taken_vec;
   logic [7:0] cpu_dly;
   logic [3:0] p;
   int err_count, cmp_count, seed, k, j, n;
   int corner[4] = '{0, 198, 199, 363};

   ppic_scheduler ppic_scheduler_i (.i_clock(i_clock), .i_rst(i_rst), .i_periph_req(preq),
      .i_hw_ack(hw_ack), .i_end_hndl(end_hndl), .o_irq(irq), .o_vector(vec),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));
   ppic_cpu_model ppic_cpu_model_i (.i_clock(i_clock), .i_rst(i_rst), .i_irq(irq),
      .i_vector(vec), .i_en(cpu_en), .i_dly(cpu_dly), .o_hw_ack(hw_ack),
      .o_end_hndl(end_hndl), .o_taken_vec(taken_vec));

   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [11:0] prio_a(input int i);
      return ppic_pkg::OFS_PRIO_BASE + 12'(4 * i);
   endfunction
   // reserved slots keep no priority
   function automatic logic [31:0] exp_prio(input int i, input logic [3:0] v);
      return (i < ppic_pkg::NUM_SW + ppic_pkg::NUM_ACTIVE) ? {28'h000_0000, v} : 32'h0000_0000;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge i_clock);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      // no limit here: only the watchdog ends a hung access
      do begin
         @(posedge i_clock);
         t++;
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      // one wait state: low is seen at the second edge after the request rises
      chk(32'(t), 32'h0000_0002);
   endtask
   // n counts edges until irq, hw_ack or end_hndl (picked by which) is seen, the raising edge included
   task automatic wait_for(input int which, input int lim);
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while ((which == 0 ? irq : which == 1 ? hw_ack : end_hndl) !== 1'b1 && n < lim);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge i_clock);
      err_count++;
      results();
   end

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   initial begin
      seed = 32'h87bf_323d;
      {rd, wr, cpu_en} = 3'b000;
      i_rst = 1'b1;
      preq = '0;
      addr = '0;
      wdata = '0;
      cpu_dly = 8'h04;
      err_count = 0;
      cmp_count = 0;
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      bus(1'b0, ppic_pkg::OFS_CTRL, 0);
      chk(q, 32'h0000_0000);
      for (j = 0; j < 8; j++) begin
         k = (j < 4) ? corner[j] : {$random(seed)} % 364;
         p = 4'($random(seed));
         bus(1'b1, prio_a(k), {28'h000_0000, p});
         bus(1'b0, prio_a(k), 0);
         chk(q, exp_prio(k, p));
      end
      bus(1'b1, 12'h020, 32'hffff_ffff);
      bus(1'b0, 12'h020, 0);
      chk(q, 32'h0000_0000);
      k = 1 + {$random(seed)} % 188;
      bus(1'b1, prio_a(7 + k), 32'h0000_0005);
      bus(1'b1, prio_a(8 + k), 32'h0000_0005);
      bus(1'b1, prio_a(9 + k), 32'h0000_0009);
      preq[k - 1] <= 1'b1;
      preq[k] <= 1'b1;
      wait_for(0, 12);
      chk(32'(n), 32'(ppic_pkg::REQ_LATENCY_CLK + 1));
      chk(32'(vec), 32'(7 + k));
      bus(1'b0, ppic_pkg::OFS_VEC_ACK, 0);
      chk(32'(q[8:0]), 32'(7 + k));
      preq[k + 1] <= 1'b1;
      wait_for(0, 12);
      chk(32'(n), 32'(ppic_pkg::REQ_LATENCY_CLK + 1));
      chk(32'(vec), 32'(9 + k));
      bus(1'b0, ppic_pkg::OFS_VEC_ACK, 0);
      bus(1'b0, ppic_pkg::OFS_STATUS, 0);
      chk(32'({q[28:24], q[16]}), 32'h0000_0004);
      preq <= '0;
      bus(1'b1, ppic_pkg::OFS_END_HNDL, 0);
      bus(1'b0, ppic_pkg::OFS_CUR_PRIO, 0);
      chk(32'(q[3:0]), 32'h0000_0005);
      bus(1'b1, ppic_pkg::OFS_END_HNDL, 0);
      bus(1'b1, ppic_pkg::OFS_END_HNDL, 0);
      bus(1'b0, ppic_pkg::OFS_CUR_PRIO, 0);
      chk(32'(q[3:0]), 32'h0000_0000);
      preq[200] <= 1'b1;
      wait_for(0, 8);
      chk(32'(irq), 32'h0000_0000);
      bus(1'b1, ppic_pkg::OFS_CUR_PRIO, 32'h0000_000f);
      bus(1'b1, prio_a(8 + k), 32'h0000_000e);
      preq[k] <= 1'b1;
      wait_for(0, 8);
      chk(32'(irq), 32'h0000_0000);
      bus(1'b1, ppic_pkg::OFS_CUR_PRIO, 32'h0000_000d);
      wait_for(0, 8);
      chk(32'(vec), 32'(8 + k));
      preq <= '0;
      bus(1'b1, ppic_pkg::OFS_CUR_PRIO, 0);
      for (j = 0; j < 8; j++) begin
         bus(1'b1, prio_a(j), 32'(j + 1));
         bus(1'b1, ppic_pkg::OFS_SW_REQ, 32'(1 << j));
         wait_for(0, 8);
         chk(32'(vec), 32'(j));
         bus(1'b0, ppic_pkg::OFS_SW_REQ, 0);
         chk(32'(q[7:0]), 32'(1 << j));
         bus(1'b1, ppic_pkg::OFS_SW_REQ, 32'(1 << (j + 8)));
      end
      bus(1'b1, ppic_pkg::OFS_CTRL, 32'h0000_0001);
      cpu_en <= 1'b1;
      for (j = 0; j < 3; j++) begin
         k = {$random(seed)} % 191;
         bus(1'b1, prio_a(8 + k), 32'h0000_0007);
         cpu_dly <= 8'(4 + {$random(seed)} % 4);
         preq[k] <= 1'b1;
         wait_for(1, 40);
         chk(32'(taken_vec), 32'(8 + k));
         preq[k] <= 1'b0;
         bus(1'b0, ppic_pkg::OFS_STATUS, 0);
         chk(32'(q[28:24]), 32'h0000_0001);
         wait_for(2, 40);
         bus(1'b0, ppic_pkg::OFS_STATUS, 0);
         chk(32'(q[28:24]), 32'h0000_0000);
      end
      results();
   end
endmodule
